/* File: common/copdo_params.svh */
// Constants for the process-data and network-state handler.
`ifndef COPDO_PARAMS_SVH
`define COPDO_PARAMS_SVH
`define COPDO_RUN_CODE 4'h5
`define COPDO_HALT_CODE 4'h6
`define COPDO_RX_BASE 16'h1400
`define COPDO_RX_LAST 16'h15FF
`define COPDO_TX_BASE 16'h1800
`define COPDO_TX_LAST 16'h19FF
`define COPDO_NOBJ 32
`define COPDO_IDX_W 5
`define COPDO_MAX_BYTES 4'h8
`define COPDO_ID_LSB 0
`define COPDO_ID_MSB 10
`define COPDO_EN_BIT 31
`define COPDO_SYNC_ID 11'h080
`define COPDO_TICK_NS 100000
`define COPDO_CLK_NS 10
`define COPDO_TICK_CYC (`COPDO_TICK_NS / `COPDO_CLK_NS)
`define COPDO_REG_CTRL 12'h000
`define COPDO_REG_STAT 12'h004
`define COPDO_REG_NMT 12'h008
`define COPDO_REG_SEL 12'h00C
`define COPDO_REG_COBID 12'h010
`define COPDO_REG_TIMER 12'h014
`define COPDO_REG_DLO 12'h018
`define COPDO_REG_DHI 12'h01C
`define COPDO_REG_RXDLO 12'h020
`define COPDO_REG_RXDHI 12'h024
`define COPDO_REG_EVT 12'h028
`define COPDO_REG_RTR 12'h02C
`define COPDO_REG_WDERR 12'h030
`define COPDO_REG_IMAGE 12'h034
`define COPDO_REG_DICT 12'h038
`endif

/* File: common/copdo_pkg.sv */
// Types shared by the process-data and network-state handler.
`default_nettype none
package copdo_pkg;
  typedef enum logic [1:0] {
    COPDO_STOPPED,
    COPDO_PREOP,
    COPDO_OPER
  } copdo_nmt_t;
endpackage
`default_nettype wire

/* File: common/copdo_tick_if.sv */
// Carrier between the handler and its timebase divider.
`default_nettype none
interface copdo_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire

/* File: hdl/copdo_core.sv */
// Process-data object handler with network-state control over APB.
`default_nettype none
`include "copdo_params.svh"
module copdo_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic tx_valid,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic tx_ready,
  output logic error_state,
  output logic sync_pulse
);
  localparam int N = `COPDO_NOBJ;

  copdo_tick_if tkif ();
  copdo_tick u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .tk(tkif.src)
  );

  logic [31:0] tx_cob_reg [N];
  logic [31:0] rx_cob_reg [N];
  logic [15:0] tx_tmr_reg [N];
  logic [15:0] rx_tmr_reg [N];
  logic [15:0] tx_cnt_reg [N];
  logic [15:0] rx_cnt_reg [N];
  logic [63:0] tx_dat_reg [N];
  logic [63:0] rx_pend_reg [N];
  logic [63:0] rx_out_reg [N];
  logic [3:0] tx_len_reg [N];
  logic [N-1:0] tx_req_reg;
  logic [N-1:0] rx_sync_reg;
  logic [N-1:0] rx_pendv_reg;
  logic [N-1:0] rtr_reg;
  logic [N-1:0] wderr_reg;
  logic [N-1:0] rx_seen_reg;
  logic [5:0] sel_reg;
  logic [15:0] dict_reg;
  logic [15:0] img_reg;
  logic [3:0] nmt_code_reg;
  logic [1:0] nmt_arg_reg;
  logic comm_reset_reg;
  copdo_pkg::copdo_nmt_t nmt_reg;

  logic wr_en;
  logic rd_en;
  logic [4:0] idx;
  logic is_tx;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign idx = sel_reg[4:0];
  assign is_tx = sel_reg[5];

  function automatic logic obj_on(input logic [31:0] cob);
    obj_on = !cob[`COPDO_EN_BIT];
  endfunction

  function automatic logic [10:0] obj_id(input logic [31:0] cob);
    obj_id = cob[`COPDO_ID_MSB:`COPDO_ID_LSB];
  endfunction

  logic rx_std;
  logic rx_is_sync;
  assign rx_std = rx_valid && !rx_ide;
  assign rx_is_sync = rx_std && !rx_rtr && rx_id == `COPDO_SYNC_ID;

  logic [N-1:0] rx_hit;
  logic [N-1:0] rtr_hit;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      rx_hit[i] = rx_std && !rx_rtr && !rx_is_sync && obj_on(rx_cob_reg[i]) &&
                  obj_id(rx_cob_reg[i]) == rx_id;
      rtr_hit[i] = rx_std && rx_rtr && obj_on(tx_cob_reg[i]) &&
                   obj_id(tx_cob_reg[i]) == rx_id;
    end
  end

  logic [4:0] tx_pick;
  logic tx_any;
  always_comb begin
    tx_pick = 5'h0;
    tx_any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (tx_req_reg[i] && obj_on(tx_cob_reg[i])) begin
        tx_pick = 5'(i);
        tx_any = 1'b1;
      end
    end
  end

  logic oper;
  logic launch;
  assign oper = nmt_reg == copdo_pkg::COPDO_OPER;
  assign launch = tx_any && oper && (!tx_valid || tx_ready);

  // Network-state commands; a write of code and argument acts once.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nmt_reg <= copdo_pkg::COPDO_PREOP;
      comm_reset_reg <= 1'b0;
    end else begin
      comm_reset_reg <= 1'b0;
      if (wr_en && paddr == `COPDO_REG_NMT) begin
        if (pwdata[3:0] == `COPDO_RUN_CODE) begin
          case (pwdata[5:4])
            2'h0: if (nmt_reg == copdo_pkg::COPDO_OPER) nmt_reg <= copdo_pkg::COPDO_PREOP;
            2'h1: begin
              if (nmt_reg != copdo_pkg::COPDO_OPER) nmt_reg <= copdo_pkg::COPDO_OPER;
              if (nmt_reg == copdo_pkg::COPDO_STOPPED) comm_reset_reg <= 1'b1;
            end
            2'h2: if (nmt_reg == copdo_pkg::COPDO_STOPPED) nmt_reg <= copdo_pkg::COPDO_PREOP;
            2'h3: if (nmt_reg == copdo_pkg::COPDO_STOPPED) nmt_reg <= copdo_pkg::COPDO_OPER;
            default: nmt_reg <= nmt_reg;
          endcase
        end else if (pwdata[3:0] == `COPDO_HALT_CODE && pwdata[5:4] == 2'h0) begin
          nmt_reg <= copdo_pkg::COPDO_STOPPED;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      nmt_code_reg <= 4'h0;
      nmt_arg_reg <= 2'h0;
      sel_reg <= 6'h00;
      dict_reg <= `COPDO_RX_BASE;
    end else if (wr_en) begin
      if (paddr == `COPDO_REG_NMT) begin
        nmt_code_reg <= pwdata[3:0];
        nmt_arg_reg <= pwdata[5:4];
      end
      if (paddr == `COPDO_REG_SEL) begin
        sel_reg <= pwdata[5:0];
        dict_reg <= pwdata[5] ? `COPDO_TX_BASE + 16'(pwdata[4:0])
                              : `COPDO_RX_BASE + 16'(pwdata[4:0]);
      end
    end
  end

  // Per-object configuration; the communication reset disables all objects.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        tx_cob_reg[i] <= 32'h8000_0000;
        rx_cob_reg[i] <= 32'h8000_0000;
        tx_tmr_reg[i] <= 16'h0000;
        rx_tmr_reg[i] <= 16'h0000;
        tx_len_reg[i] <= 4'h0;
      end
    end else if (comm_reset_reg) begin
      for (int i = 0; i < N; i++) begin
        tx_cob_reg[i] <= 32'h8000_0000;
        rx_cob_reg[i] <= 32'h8000_0000;
      end
    end else if (wr_en) begin
      if (paddr == `COPDO_REG_COBID) begin
        if (is_tx) tx_cob_reg[idx] <= {pwdata[31], 20'h0_0000, pwdata[10:0]};
        else rx_cob_reg[idx] <= {pwdata[31], 20'h0_0000, pwdata[10:0]};
      end
      if (paddr == `COPDO_REG_TIMER) begin
        if (is_tx) tx_tmr_reg[idx] <= pwdata[15:0];
        else rx_tmr_reg[idx] <= pwdata[15:0];
      end
      if (paddr == `COPDO_REG_CTRL && is_tx) begin
        tx_len_reg[idx] <= pwdata[3:0] > `COPDO_MAX_BYTES ? `COPDO_MAX_BYTES : pwdata[3:0];
      end
    end
  end

  // Transmit data, event and timer handling.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        tx_dat_reg[i] <= 64'h0000_0000_0000_0000;
        tx_cnt_reg[i] <= 16'h0000;
      end
      tx_req_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        // Data is stored even while the object is off, so software can load it before enabling.
        if (wr_en && is_tx && idx == 5'(i) && paddr == `COPDO_REG_DLO) tx_dat_reg[i][31:0] <= pwdata;
        if (wr_en && is_tx && idx == 5'(i) && paddr == `COPDO_REG_DHI) tx_dat_reg[i][63:32] <= pwdata;
        if (!obj_on(tx_cob_reg[i])) begin
          tx_req_reg[i] <= 1'b0;
          tx_cnt_reg[i] <= 16'h0000;
        end else if (wr_en && is_tx && idx == 5'(i) &&
                     (paddr == `COPDO_REG_DLO || paddr == `COPDO_REG_DHI)) begin
          if ((paddr == `COPDO_REG_DLO && pwdata != tx_dat_reg[i][31:0]) ||
              (paddr == `COPDO_REG_DHI && pwdata != tx_dat_reg[i][63:32])) begin
            tx_req_reg[i] <= 1'b1;
            tx_cnt_reg[i] <= 16'h0000;
          end
        end else if (launch && tx_pick == 5'(i)) begin
          tx_req_reg[i] <= 1'b0;
          tx_cnt_reg[i] <= 16'h0000;
        end else if (tkif.tick && tx_tmr_reg[i] != 16'h0000) begin
          if (tx_cnt_reg[i] + 16'h0001 >= tx_tmr_reg[i]) begin
            tx_req_reg[i] <= 1'b1;
            tx_cnt_reg[i] <= 16'h0000;
          end else begin
            tx_cnt_reg[i] <= tx_cnt_reg[i] + 16'h0001;
          end
        end
      end
    end
  end

  // Transmit port holds a frame until the controller takes it.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_valid <= 1'b0;
      tx_id <= 11'h000;
      tx_dlc <= 4'h0;
      tx_data <= 64'h0000_0000_0000_0000;
    end else if (launch) begin
      tx_valid <= 1'b1;
      tx_id <= obj_id(tx_cob_reg[tx_pick]);
      tx_dlc <= tx_len_reg[tx_pick];
      tx_data <= tx_dat_reg[tx_pick];
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Remote requests go to software, which refreshes data to send fresh values.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rtr_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (rtr_hit[i]) rtr_reg[i] <= 1'b1;
        else if (wr_en && paddr == `COPDO_REG_RTR && pwdata[i]) rtr_reg[i] <= 1'b0;
      end
    end
  end

  // Receive path: in synchronous mode buffered until the next sync makes it valid; otherwise written straight to the output.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        rx_pend_reg[i] <= 64'h0000_0000_0000_0000;
        rx_out_reg[i] <= 64'h0000_0000_0000_0000;
      end
      rx_pendv_reg <= '0;
      rx_sync_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (wr_en && paddr == `COPDO_REG_CTRL && !is_tx && idx == 5'(i)) rx_sync_reg[i] <= pwdata[4];
        if (rx_hit[i]) begin
          if (rx_sync_reg[i]) begin
            rx_pend_reg[i] <= rx_data;
            rx_pendv_reg[i] <= 1'b1;
          end else begin
            rx_out_reg[i] <= rx_data;
          end
        end else if (rx_is_sync && rx_pendv_reg[i]) begin
          rx_out_reg[i] <= rx_pend_reg[i];
          rx_pendv_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Watchdog starts after first arrival so a silent producer at start-up is not an error.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) rx_cnt_reg[i] <= 16'h0000;
      rx_seen_reg <= '0;
      wderr_reg <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (!obj_on(rx_cob_reg[i]) || rx_tmr_reg[i] == 16'h0000) begin
          rx_cnt_reg[i] <= 16'h0000;
          rx_seen_reg[i] <= 1'b0;
        end else if (rx_hit[i]) begin
          rx_cnt_reg[i] <= 16'h0000;
          rx_seen_reg[i] <= 1'b1;
        end else if (tkif.tick && rx_seen_reg[i]) begin
          if (rx_cnt_reg[i] + 16'h0001 >= rx_tmr_reg[i]) begin
            wderr_reg[i] <= 1'b1;
            rx_seen_reg[i] <= 1'b0;
          end else begin
            rx_cnt_reg[i] <= rx_cnt_reg[i] + 16'h0001;
          end
        end
        if (wr_en && paddr == `COPDO_REG_WDERR && pwdata[i] &&
            !(tkif.tick && rx_seen_reg[i] && rx_cnt_reg[i] + 16'h0001 >= rx_tmr_reg[i])) begin
          wderr_reg[i] <= 1'b0;
        end
      end
    end
  end

  function automatic logic [15:0] image_size(input logic [31:0] c [N], input logic [3:0] l [N]);
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < N; i++) if (obj_on(c[i])) s = s + 16'(l[i]);
    image_size = s;
  endfunction

  // Image size is the packed sum of enabled object lengths.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      img_reg <= 16'h0000;
      error_state <= 1'b0;
      sync_pulse <= 1'b0;
    end else begin
      img_reg <= image_size(tx_cob_reg, tx_len_reg);
      error_state <= |wderr_reg;
      sync_pulse <= rx_is_sync && oper;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `COPDO_REG_CTRL: prdata <= {27'h000_0000, rx_sync_reg[idx], tx_len_reg[idx]};
          `COPDO_REG_STAT: prdata <= {29'h0000_0000, error_state, nmt_reg};
          `COPDO_REG_NMT: prdata <= {26'h000_0000, nmt_arg_reg, nmt_code_reg};
          `COPDO_REG_SEL: prdata <= {26'h000_0000, sel_reg};
          `COPDO_REG_COBID: prdata <= is_tx ? tx_cob_reg[idx] : rx_cob_reg[idx];
          `COPDO_REG_TIMER: prdata <= {16'h0000, is_tx ? tx_tmr_reg[idx] : rx_tmr_reg[idx]};
          `COPDO_REG_DLO: prdata <= tx_dat_reg[idx][31:0];
          `COPDO_REG_DHI: prdata <= tx_dat_reg[idx][63:32];
          `COPDO_REG_RXDLO: prdata <= rx_out_reg[idx][31:0];
          `COPDO_REG_RXDHI: prdata <= rx_out_reg[idx][63:32];
          `COPDO_REG_EVT: prdata <= tx_req_reg;
          `COPDO_REG_RTR: prdata <= rtr_reg;
          `COPDO_REG_WDERR: prdata <= wderr_reg;
          `COPDO_REG_IMAGE: prdata <= {16'h0000, img_reg};
          `COPDO_REG_DICT: prdata <= {16'h0000, dict_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  run_to_pre_a: assert property (@(posedge mclk) disable iff (!rstn)
    (wr_en && paddr == `COPDO_REG_NMT && pwdata[5:0] == 6'h05 && nmt_reg == copdo_pkg::COPDO_OPER)
    |=> nmt_reg == copdo_pkg::COPDO_PREOP) else $error("Run code 0 did not enter preoperational.");
  halt_stop_a: assert property (@(posedge mclk) disable iff (!rstn)
    (wr_en && paddr == `COPDO_REG_NMT && pwdata[5:0] == 6'h06)
    |=> nmt_reg == copdo_pkg::COPDO_STOPPED) else $error("Halt code did not stop.");
  dlc_limit_a: assert property (@(posedge mclk) disable iff (!rstn)
    tx_valid |-> tx_dlc <= `COPDO_MAX_BYTES) else $error("Frame length above eight.");
  ext_ignore_a: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_valid && rx_ide) |-> rx_hit == '0) else $error("Extended frame accepted.");
  stop_no_tx_a: assert property (@(posedge mclk) disable iff (!rstn)
    !oper |=> !$rose(tx_valid)) else $error("Transmit while not operational.");
  sync_valid_a: assert property (@(posedge mclk) disable iff (!rstn)
    (rx_is_sync && rx_pendv_reg[0] && !rx_hit[0]) |=> rx_out_reg[0] == $past(rx_pend_reg[0]))
    else $error("Pending data not released at sync.");
  wd_error_a: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(wderr_reg[0]) |=> error_state) else $error("Watchdog did not raise error.");
  rtr_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
    rtr_hit[0] |=> rtr_reg[0]) else $error("Remote request not forwarded.");
endmodule
`default_nettype wire

/* File: hdl/copdo_tick.sv */
// Timebase divider giving a one-cycle tick every event-timer unit.
`default_nettype none
`include "copdo_params.svh"
module copdo_tick (
  input wire logic mclk,
  input wire logic rstn,
  copdo_tick_if.src tk
);
  logic [15:0] cnt_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 16'h0000;
      tk.tick <= 1'b0;
    end else if (cnt_reg == 16'(`COPDO_TICK_CYC - 1)) begin
      cnt_reg <= 16'h0000;
      tk.tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tk.tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/copdo_can_node.sv */
// Peer node model on the bus side of the process-data handler.
`default_nettype none
module copdo_can_node (
  input wire logic mclk,
  input wire logic tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [10:0] rx_id,
  output logic rx_ide,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int stall = 0;
  int wait_cnt = 0;
  int n_tx = 0;
  logic [10:0] last_id;
  logic [3:0] last_dlc;
  logic [63:0] last_data;

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_id = 11'h000;
    rx_ide = 1'b0;
    rx_rtr = 1'b0;
    rx_dlc = 4'h0;
    rx_data = 64'h0000_0000_0000_0000;
  end

  // The node only consumes what the handler produces; it never answers with the handler's identifier.
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      n_tx <= n_tx + 1;
      last_id <= tx_id;
      last_dlc <= tx_dlc;
      last_data <= tx_data;
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid) begin
      // A slow controller holds acceptance off for stall + 1 cycles.
      tx_ready <= (wait_cnt >= stall);
      wait_cnt <= wait_cnt + 1;
    end
  end

  // One whole frame per call, never more than eight bytes; lines are scrambled once released.
  task send(input logic [10:0] id, input logic ide, input logic rtr, input logic [3:0] dlc,
            input logic [63:0] d);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_ide <= ide;
    rx_rtr <= rtr;
    rx_dlc <= dlc;
    rx_data <= d;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_ide <= ~ide;
    rx_rtr <= ~rtr;
    rx_dlc <= ~dlc;
    rx_data <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: sim/copdo_core_test.sv */
// Self-checking bench for the process-data and network-state handler.
`default_nettype none
`include "copdo_params.svh"
module copdo_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] wa; logic [31:0] wd; logic [11:0] ra; logic [31:0] ex;} copdo_row_t;
  logic mclk, rstn, psel, penable, pwrite, pready, pslverr, errv;
  logic tx_valid, tx_ready, rx_valid, rx_ide, rx_rtr, error_state, sync_pulse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [10:0] tx_id, rx_id;
  logic [3:0] tx_dlc, rx_dlc;
  logic [63:0] tx_data, rx_data;
  int fails = 0;
  int checks = 0;
  int n_sync = 0;
  int t;
  copdo_row_t rows[12] = '{
    '{`COPDO_REG_NMT, 32'h0000_0015, `COPDO_REG_STAT, 32'h0000_0002},
    '{`COPDO_REG_NMT, 32'h0000_0005, `COPDO_REG_STAT, 32'h0000_0001},
    '{`COPDO_REG_NMT, 32'h0000_0006, `COPDO_REG_STAT, 32'h0000_0000},
    '{`COPDO_REG_NMT, 32'h0000_0035, `COPDO_REG_STAT, 32'h0000_0002},
    '{`COPDO_REG_NMT, 32'h0000_0006, `COPDO_REG_STAT, 32'h0000_0000},
    '{`COPDO_REG_NMT, 32'h0000_0025, `COPDO_REG_STAT, 32'h0000_0001},
    '{`COPDO_REG_SEL, 32'h0000_0023, `COPDO_REG_DICT, 32'h0000_1803},
    '{`COPDO_REG_SEL, 32'h0000_003F, `COPDO_REG_DICT, 32'h0000_181F},
    '{`COPDO_REG_SEL, 32'h0000_0005, `COPDO_REG_DICT, 32'h0000_1405},
    '{`COPDO_REG_SEL, 32'h0000_001F, `COPDO_REG_DICT, 32'h0000_141F},
    '{`COPDO_REG_COBID, 32'h8000_0201, `COPDO_REG_COBID, 32'h8000_0201},
    '{12'h03C, 32'h0000_1234, 12'h03C, 32'h0000_0000}};

  copdo_core dut_u (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data),
    .tx_ready(tx_ready), .error_state(error_state), .sync_pulse(sync_pulse));
  copdo_can_node node_u (.mclk(mclk), .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ide(rx_ide),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (sync_pulse === 1'b1) begin
      n_sync <= n_sync + 1;
    end
  end

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request stands from setup until pready is sampled high; an edge always separates two requests.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_tx(input int n, input int lim);
    t = 0;
    while (node_u.n_tx < n && t < lim) begin
      @(posedge mclk);
      t++;
    end
  endtask

  task complete_run;
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    complete_run();
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    apb(1'b0, `COPDO_REG_STAT, 32'h0000_0000);
    check(rdv, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, rows[i].wa, rows[i].wd);
      apb(1'b0, rows[i].ra, 32'h0000_0000);
      check(rdv, rows[i].ex);
      check(errv, rows[i].ra == 12'h03C);
    end
    // Leaving the stopped state with code 1 must also switch every object off.
    apb(1'b1, `COPDO_REG_NMT, 32'h0000_0006);
    apb(1'b1, `COPDO_REG_SEL, 32'h0000_0020);
    apb(1'b1, `COPDO_REG_COBID, 32'h0000_0181);
    apb(1'b1, `COPDO_REG_NMT, 32'h0000_0015);
    apb(1'b0, `COPDO_REG_COBID, 32'h0000_0000);
    check(rdv[31], 1'b1);
    apb(1'b1, `COPDO_REG_CTRL, 32'h0000_0008);
    apb(1'b1, `COPDO_REG_COBID, 32'h8000_0181);
    apb(1'b1, `COPDO_REG_DHI, 32'h5566_7788);
    apb(1'b1, `COPDO_REG_DLO, 32'h1122_3340);
    repeat (20) @(posedge mclk);
    check(node_u.n_tx, 0);
    apb(1'b1, `COPDO_REG_COBID, 32'h0000_0181);
    apb(1'b1, `COPDO_REG_DLO, 32'h1122_3344);
    wait_tx(1, 50);
    check(node_u.n_tx, 1);
    check(node_u.last_id, 11'h181);
    check(node_u.last_dlc, 4'h8);
    check(node_u.last_data, 64'h5566_7788_1122_3344);
    apb(1'b0, `COPDO_REG_IMAGE, 32'h0000_0000);
    check(rdv, 32'h0000_0008);
    node_u.stall = 4;
    apb(1'b1, `COPDO_REG_TIMER, 32'h0000_0001);
    wait_tx(2, 25000);
    check(node_u.n_tx, 2);
    check(node_u.last_data, 64'h5566_7788_1122_3344);
    apb(1'b1, `COPDO_REG_TIMER, 32'h0000_0000);
    node_u.stall = 0;
    apb(1'b1, `COPDO_REG_SEL, 32'h0000_0000);
    apb(1'b1, `COPDO_REG_CTRL, 32'h0000_0000);
    apb(1'b1, `COPDO_REG_COBID, 32'h0000_0201);
    apb(1'b1, `COPDO_REG_TIMER, 32'h0000_0002);
    node_u.send(11'h202, 1'b0, 1'b0, 4'h8, 64'hAAAA_5555_AAAA_5555);
    node_u.send(11'h201, 1'b1, 1'b0, 4'h8, 64'hAAAA_5555_AAAA_5555);
    apb(1'b0, `COPDO_REG_RXDLO, 32'h0000_0000);
    check(rdv, 32'h0000_0000);
    node_u.send(11'h201, 1'b0, 1'b0, 4'h8, 64'h0123_4567_89AB_CDEF);
    apb(1'b0, `COPDO_REG_RXDLO, 32'h0000_0000);
    check(rdv, 32'h89AB_CDEF);
    apb(1'b0, `COPDO_REG_RXDHI, 32'h0000_0000);
    check(rdv, 32'h0123_4567);
    // In synchronous mode new data must wait for the next sync frame.
    apb(1'b1, `COPDO_REG_CTRL, 32'h0000_0010);
    node_u.send(11'h201, 1'b0, 1'b0, 4'h8, 64'h0000_0000_5A5A_A5A5);
    apb(1'b0, `COPDO_REG_RXDLO, 32'h0000_0000);
    check(rdv, 32'h89AB_CDEF);
    t = n_sync;
    node_u.send(`COPDO_SYNC_ID, 1'b0, 1'b0, 4'h0, 64'h0000_0000_0000_0000);
    apb(1'b0, `COPDO_REG_RXDLO, 32'h0000_0000);
    check(rdv, 32'h5A5A_A5A5);
    check(n_sync, t + 1);
    node_u.send(11'h181, 1'b0, 1'b1, 4'h0, 64'h0000_0000_0000_0000);
    apb(1'b0, `COPDO_REG_RTR, 32'h0000_0000);
    check(rdv, 32'h0000_0001);
    check(error_state, 1'b0);
    t = 0;
    while (error_state !== 1'b1 && t < 35000) begin
      @(posedge mclk);
      t++;
    end
    check(error_state, 1'b1);
    apb(1'b0, `COPDO_REG_STAT, 32'h0000_0000);
    check(rdv[2], 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
